/* codec_serial_interface_consts.vh */
// constants and register layout of the codec serial port
`ifndef CODEC_SERIAL_INTERFACE_CONSTS_VH
`define CODEC_SERIAL_INTERFACE_CONSTS_VH
// ***************************************
// register byte offsets
// ***************************************
`define ADDR_CONTROL_1 8'h00
`define ADDR_CONTROL_2 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RX_SLOT_MASK 8'h0c
`define ADDR_TX_SLOT_MASK 8'h10
`define ADDR_TX_DATA 8'h14
`define ADDR_RX_DATA 8'h18
`define ADDR_CLOCK_DIVIDER 8'h1c
// ***************************************
// field positions
// ***************************************
`define BIT_PORT_ENABLE 15
`define BIT_IDLE_STOP 13
`define BIT_LOOPBACK 11
`define BIT_CLOCK_DIR 10
`define BIT_CLOCK_EDGE 9
`define BIT_FSYNC_DIR 8
`define BIT_UNDERFLOW_MODE 7
`define BIT_OUTPUT_IDLE_MODE 6
`define BIT_DATA_JUSTIFY 5
`define MASK_CONTROL_1 16'hafe3
`define MASK_CONTROL_2 16'h0def
`define BIT_ROV 3
`define BIT_RECEIVE_FULL_FLAG 2
`define BIT_TRANSMIT_UNDERFLOW_FLAG 1
`define BIT_TRANSMIT_EMPTY_FLAG 0
// ***************************************
// framing codes, reset values, sizes
// ***************************************
`define FRAMING_MULTI 2'h0
`define FRAMING_I2S 2'h1
`define FRAMING_AC16 2'h2
`define FRAMING_AC20 2'h3
`define AC_LAST_SLOT 4'hc
`define AC_TAG_LAST_BIT 5'h0f
`define AC20_LAST_BIT 5'h13
`define RESET_CONTROL 16'h0000
`define RESET_DIVIDER 12'h000
`define BUFFER_DEPTH 4
`endif

/* sample_buffer.v */
// small sample memory with registered read data
`timescale 1ns/1ps
module sample_buffer #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // write side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // read side
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= {WIDTH{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

/* codec_serial_interface.v */
// codec serial port: apb registers, bit clock, framing and shift engine
`timescale 1ns/1ps
`include "codec_serial_interface_consts.vh"
module codec_serial_interface #(
  parameter DEPTH = `BUFFER_DEPTH
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // processor idle indication
  input wire cpu_idle,
  // serial bit clock pin
  input wire serial_bit_clock_in,
  output reg serial_bit_clock_out,
  output reg serial_bit_clock_oe,
  // frame sync pin
  input wire frame_sync_pin_in,
  output reg frame_sync_pin_out,
  output reg frame_sync_pin_oe,
  // serial data
  input wire serial_data_in,
  output reg serial_data_out,
  output reg serial_data_oe
);
  // ***************************************
  // registers
  // ***************************************
  reg [15:0] control_1;
  reg [15:0] control_2;
  reg [15:0] receive_slot_mask;
  reg [15:0] transmit_slot_mask;
  reg [11:0] clock_divider;
  reg receive_overflow_flag;
  reg transmit_underflow_flag;
  reg [15:0] last_written;
  reg [2:0] tx_cnt;
  reg [2:0] rx_cnt;
  reg [1:0] tx_wr;
  reg [1:0] tx_rd;
  reg [1:0] rx_wr;
  reg [1:0] rx_rd;
  wire [15:0] tx_q;
  wire [15:0] rx_q;
  wire apb_tx_write;

  wire port_enable = control_1[`BIT_PORT_ENABLE];
  wire idle_stop = control_1[`BIT_IDLE_STOP];
  wire loopback_enable = control_1[`BIT_LOOPBACK];
  wire serial_clock_direction = control_1[`BIT_CLOCK_DIR];
  wire serial_clock_edge = control_1[`BIT_CLOCK_EDGE];
  wire frame_sync_direction = control_1[`BIT_FSYNC_DIR];
  wire underflow_mode = control_1[`BIT_UNDERFLOW_MODE];
  wire output_idle_mode = control_1[`BIT_OUTPUT_IDLE_MODE];
  wire data_justify = control_1[`BIT_DATA_JUSTIFY];
  wire [1:0] framing_mode = control_1[1:0];
  wire [1:0] buffer_length = control_2[11:10];
  wire [3:0] words_per_frame = control_2[8:5];
  wire [3:0] word_length = control_2[3:0];
  wire [2:0] capacity = {1'b0, buffer_length} + 3'h1;
  wire run = port_enable & ~(idle_stop & cpu_idle);

  // ***************************************
  // frame geometry
  // ***************************************
  reg [4:0] bit_idx;
  reg [3:0] slot_idx;
  reg fresh;

  // last bit index of a slot
  function [4:0] last_bit;
    input [3:0] s;
    begin
      if (framing_mode == `FRAMING_AC20) begin
        last_bit = (s == 4'h0) ? `AC_TAG_LAST_BIT : `AC20_LAST_BIT;
      end else if (framing_mode == `FRAMING_AC16) begin
        last_bit = `AC_TAG_LAST_BIT;
      end else begin
        last_bit = {1'b0, word_length};
      end
    end
  endfunction

  // last slot index of a frame
  function [3:0] last_slot;
    input dummy;
    begin
      last_slot = framing_mode[1] ? `AC_LAST_SLOT : words_per_frame;
    end
  endfunction

  // position one bit later: {slot, bit}
  function [8:0] step;
    input [3:0] s;
    input [4:0] b;
    begin
      if (b == last_bit(s)) begin
        step = {((s == last_slot(1'b0)) ? 4'h0 : s + 4'h1), 5'h00};
      end else begin
        step = {s, b + 5'h01};
      end
    end
  endfunction

  // ***************************************
  // pin synchronisers and edge detection
  // ***************************************
  reg sck_s1, sck_s2, sck_s3;
  reg fs_s1, fs_s2, fs_s3;
  reg sdi_s1, sdi_s2;
  reg [11:0] div_cnt;
  reg sck_int;
  wire div_tick = run & ~serial_clock_direction & (div_cnt == clock_divider);
  wire int_rise = div_tick & ~sck_int;
  wire int_fall = div_tick & sck_int;
  wire ext_rise = run & sck_s2 & ~sck_s3;
  wire ext_fall = run & ~sck_s2 & sck_s3;
  wire clk_rise = serial_clock_direction ? ext_rise : int_rise;
  wire clk_fall = serial_clock_direction ? ext_fall : int_fall;
  wire launch_evt = serial_clock_edge ? clk_fall : clk_rise;
  wire sample_evt = serial_clock_edge ? clk_rise : clk_fall;
  wire fs_edge = (framing_mode == `FRAMING_I2S) ? (~fs_s2 & fs_s3) : (fs_s2 & ~fs_s3);
  reg restart;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      fs_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sck_s1 <= serial_bit_clock_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      fs_s1 <= frame_sync_pin_in;
      fs_s2 <= fs_s1;
      fs_s3 <= fs_s2;
      sdi_s1 <= serial_data_in;
      sdi_s2 <= sdi_s1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
      sck_int <= 1'b0;
    end else if (!port_enable || serial_clock_direction) begin
      div_cnt <= 12'h000;
      sck_int <= 1'b0;
    end else if (run) begin
      if (div_tick) begin
        div_cnt <= 12'h000;
        sck_int <= ~sck_int;
      end else begin
        div_cnt <= div_cnt + 12'h001;
      end
    end
  end

  // ***************************************
  // serial engine
  // ***************************************
  reg [15:0] tx_shift;
  reg [15:0] rx_shift;
  reg tx_active;
  reg [8:0] np;
  reg [8:0] lp;
  reg tx_pop;
  reg tx_take;
  reg [15:0] tx_word;
  reg next_fs;
  wire [3:0] half_slot = last_slot(1'b0) >> 1;
  wire rx_din = loopback_enable ? serial_data_out : sdi_s2;
  wire [4:0] rx_last = framing_mode[1] ? `AC_TAG_LAST_BIT : {1'b0, word_length};
  wire [15:0] rx_mask_bits = framing_mode[1] ? 16'hffff : ~(16'hfffe << word_length);
  wire rx_push = run & sample_evt & ~fresh & (bit_idx == rx_last) &
    receive_slot_mask[slot_idx];
  wire rx_accept = rx_push & (rx_cnt != capacity);

  always @* begin
    if (fresh) begin
      np = 9'h000;
    end else if (restart) begin
      np = data_justify ? 9'h001 : 9'h000;
    end else begin
      np = step(slot_idx, bit_idx);
    end
    lp = data_justify ? np : step(np[8:5], np[4:0]);
    if (framing_mode == `FRAMING_I2S) begin
      next_fs = lp[8:5] > half_slot;
    end else if (framing_mode[1]) begin
      next_fs = lp[8:5] == 4'h0;
    end else begin
      next_fs = lp == 9'h000;
    end
    tx_take = transmit_slot_mask[np[8:5]];
    tx_pop = run & launch_evt & (np[4:0] == 5'h00) & tx_take & (tx_cnt != 3'h0);
    if (tx_cnt != 3'h0) begin
      tx_word = tx_q;
    end else begin
      tx_word = underflow_mode ? last_written : 16'h0000;
    end
    if (!framing_mode[1]) begin
      tx_word = tx_word << (4'hf - word_length);
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx <= 5'h00;
      slot_idx <= 4'h0;
      fresh <= 1'b1;
      restart <= 1'b0;
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
      tx_active <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
      frame_sync_pin_out <= 1'b0;
      frame_sync_pin_oe <= 1'b0;
      serial_bit_clock_out <= 1'b0;
      serial_bit_clock_oe <= 1'b0;
    end else if (!port_enable) begin
      fresh <= 1'b1;
      restart <= 1'b0;
      tx_active <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
      frame_sync_pin_out <= 1'b0;
      frame_sync_pin_oe <= 1'b0;
      serial_bit_clock_out <= 1'b0;
      serial_bit_clock_oe <= 1'b0;
    end else begin
      serial_bit_clock_oe <= ~serial_clock_direction;
      serial_bit_clock_out <= sck_int;
      frame_sync_pin_oe <= ~frame_sync_direction;
      if (run && frame_sync_direction && fs_edge) begin
        restart <= 1'b1;
      end else if (run && launch_evt) begin
        restart <= 1'b0;
      end
      if (run && launch_evt) begin
        fresh <= 1'b0;
        slot_idx <= np[8:5];
        bit_idx <= np[4:0];
        if (!frame_sync_direction) begin
          frame_sync_pin_out <= next_fs;
        end
        if (np[4:0] == 5'h00) begin
          tx_active <= tx_take;
          tx_shift <= tx_word;
          serial_data_out <= tx_take & tx_word[15];
          serial_data_oe <= tx_take | ~output_idle_mode;
        end else begin
          tx_shift <= {tx_shift[14:0], 1'b0};
          serial_data_out <= tx_active & tx_shift[14];
          serial_data_oe <= tx_active | ~output_idle_mode;
        end
      end
      if (run && sample_evt) begin
        rx_shift <= {rx_shift[14:0], rx_din};
      end
    end
  end

  sample_buffer #(.WIDTH(16), .DEPTH(DEPTH), .AW(2)) tx_buffer (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(apb_tx_write),
    .wr_addr(tx_wr),
    .wr_data(pwdata[15:0]),
    .rd_addr(tx_rd),
    .rd_data(tx_q)
  );

  sample_buffer #(.WIDTH(16), .DEPTH(DEPTH), .AW(2)) rx_buffer (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(rx_accept),
    .wr_addr(rx_wr),
    .wr_data({rx_shift[14:0], rx_din} & rx_mask_bits),
    .rd_addr(rx_rd),
    .rd_data(rx_q)
  );

  // ***************************************
  // apb slave
  // ***************************************
  wire apb_done = psel & penable & pready;
  wire apb_wr = apb_done & pwrite;
  assign apb_tx_write = apb_wr & (paddr == `ADDR_TX_DATA) & (tx_cnt != capacity);
  wire apb_rx_pop = apb_done & ~pwrite & (paddr == `ADDR_RX_DATA) & (rx_cnt != 3'h0);
  wire status_clear = apb_wr & (paddr == `ADDR_STATUS);
  wire tx_underflow_evt = run & launch_evt & (np[4:0] == 5'h00) & tx_take &
    (tx_cnt == 3'h0);
  reg [31:0] read_value;
  reg mapped;

  always @* begin
    read_value = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `ADDR_CONTROL_1) begin
      read_value = {16'h0000, control_1};
    end else if (paddr == `ADDR_CONTROL_2) begin
      read_value = {16'h0000, control_2};
    end else if (paddr == `ADDR_STATUS) begin
      read_value = {20'h00000, slot_idx, 4'h0, receive_overflow_flag,
        rx_cnt >= capacity, transmit_underflow_flag, tx_cnt == 3'h0};
    end else if (paddr == `ADDR_RX_SLOT_MASK) begin
      read_value = {16'h0000, receive_slot_mask};
    end else if (paddr == `ADDR_TX_SLOT_MASK) begin
      read_value = {16'h0000, transmit_slot_mask};
    end else if (paddr == `ADDR_TX_DATA) begin
      read_value = {16'h0000, last_written};
    end else if (paddr == `ADDR_RX_DATA) begin
      read_value = {16'h0000, rx_q};
    end else if (paddr == `ADDR_CLOCK_DIVIDER) begin
      read_value = {20'h00000, clock_divider};
    end else begin
      mapped = 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? 32'h0000_0000 : read_value;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_1 <= `RESET_CONTROL;
      control_2 <= `RESET_CONTROL;
      receive_slot_mask <= `RESET_CONTROL;
      transmit_slot_mask <= `RESET_CONTROL;
      clock_divider <= `RESET_DIVIDER;
      last_written <= 16'h0000;
    end else if (apb_wr) begin
      if (paddr == `ADDR_CONTROL_1) begin
        control_1 <= pwdata[15:0] & `MASK_CONTROL_1;
      end else if (paddr == `ADDR_CONTROL_2) begin
        control_2 <= pwdata[15:0] & `MASK_CONTROL_2;
      end else if (paddr == `ADDR_RX_SLOT_MASK) begin
        receive_slot_mask <= pwdata[15:0];
      end else if (paddr == `ADDR_TX_SLOT_MASK) begin
        transmit_slot_mask <= pwdata[15:0];
      end else if (paddr == `ADDR_TX_DATA) begin
        last_written <= pwdata[15:0];
      end else if (paddr == `ADDR_CLOCK_DIVIDER) begin
        clock_divider <= pwdata[11:0];
      end
    end
  end

  // buffer pointers and sticky flags; set wins over clear
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt <= 3'h0;
      rx_cnt <= 3'h0;
      tx_wr <= 2'h0;
      tx_rd <= 2'h0;
      rx_wr <= 2'h0;
      rx_rd <= 2'h0;
      receive_overflow_flag <= 1'b0;
      transmit_underflow_flag <= 1'b0;
    end else begin
      tx_cnt <= tx_cnt + {2'h0, apb_tx_write} - {2'h0, tx_pop};
      rx_cnt <= rx_cnt + {2'h0, rx_accept} - {2'h0, apb_rx_pop};
      tx_wr <= tx_wr + {1'b0, apb_tx_write};
      tx_rd <= tx_rd + {1'b0, tx_pop};
      rx_wr <= rx_wr + {1'b0, rx_accept};
      rx_rd <= rx_rd + {1'b0, apb_rx_pop};
      if (rx_push && !rx_accept) begin
        receive_overflow_flag <= 1'b1;
      end else if (status_clear && pwdata[`BIT_ROV]) begin
        receive_overflow_flag <= 1'b0;
      end
      if (tx_underflow_evt) begin
        transmit_underflow_flag <= 1'b1;
      end else if (status_clear && pwdata[`BIT_TRANSMIT_UNDERFLOW_FLAG]) begin
        transmit_underflow_flag <= 1'b0;
      end
    end
  end
endmodule

/* codec_serial_interface_props.sv */
// bus and pin checks for the codec serial port
`timescale 1ns/1ps
module codec_serial_interface_props (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins
  input wire cpu_idle,
  input wire serial_bit_clock_out,
  input wire serial_bit_clock_oe,
  input wire frame_sync_pin_oe,
  input wire serial_data_oe
);
  // ****
  // shadow of control_1 and its age
  // ****
  reg [15:0] ctl;
  reg [1:0] age;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 16'h0000;
      age <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
      ctl <= pwdata[15:0];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not two cycles after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h1c))
    else $error("error flag wrong for address");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($rose(rst_n) |-> !pready && !serial_bit_clock_oe
    && !frame_sync_pin_oe && !serial_data_oe) else $error("outputs active after reset");
  a_clock_dir: assert property (age == 2'h3 |-> serial_bit_clock_oe == (ctl[15] && !ctl[10]))
    else $error("bit clock drive wrong");
  a_fsync_dir: assert property (age == 2'h3 |-> frame_sync_pin_oe == (ctl[15] && !ctl[8]))
    else $error("frame sync drive wrong");
  a_data_off: assert property (age == 2'h3 && !ctl[15] |-> !serial_data_oe)
    else $error("data driven while disabled");
  a_idle_freeze: assert property (age == 2'h3 && ctl[15] && ctl[13] && cpu_idle &&
    $past(cpu_idle) && $past(cpu_idle, 2) |-> $stable(serial_bit_clock_out))
    else $error("clock moved in idle");
endmodule
bind codec_serial_interface codec_serial_interface_props i_props (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_idle(cpu_idle), .serial_bit_clock_out(serial_bit_clock_out),
  .serial_bit_clock_oe(serial_bit_clock_oe), .frame_sync_pin_oe(frame_sync_pin_oe),
  .serial_data_oe(serial_data_oe));

/* codec_partner.sv */
// external codec model: bit clock, frame sync and data source
`timescale 1ns/1ps
module codec_partner (
  // control
  input wire run,
  input wire [15:0] word,
  // link
  output reg sck,
  output reg fs,
  output reg sdi
);
  integer bit_n;
  initial begin
    sck = 1'b0;
    fs = 1'b0;
    sdi = 1'b0;
    bit_n = 0;
  end
  // clock only while run is high, returns low when stopped
  always #80 if (run || sck) sck = ~sck;
  // launch on rising edge, one-bit sync at bit 0, msb first
  always @(posedge sck) begin
    fs <= (bit_n == 0);
    sdi <= word[15 - bit_n];
    bit_n <= (bit_n + 1) % 16;
  end
  // released lines: sync low, data inverted
  always @(negedge run) begin
    fs <= 1'b0;
    sdi <= ~sdi;
  end
endmodule

/* test_codec_serial_interface.sv */
// testbench for the codec serial port
`timescale 1ns/1ps
`include "codec_serial_interface_consts.vh"
module test_codec_serial_interface;
  logic mclk, rst_n, psel, penable, pwrite, cpu_idle, run, pready, pslverr, err, held;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sck_out, sck_oe, fs_out, fs_oe, sdo, sdo_oe;
  wire sck, fs, sdi;
  wire ck_pin = sck_oe ? sck_out : sck;
  wire fs_pin = fs_oe ? fs_out : fs;
  logic [7:0] regs [5] = '{`ADDR_CONTROL_1, `ADDR_CONTROL_2, `ADDR_RX_SLOT_MASK,
    `ADDR_TX_SLOT_MASK, `ADDR_CLOCK_DIVIDER};
  integer failures, check_count, n;
  codec_serial_interface i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(cpu_idle), .serial_bit_clock_in(ck_pin),
    .serial_bit_clock_out(sck_out), .serial_bit_clock_oe(sck_oe), .frame_sync_pin_in(fs_pin),
    .frame_sync_pin_out(fs_out), .frame_sync_pin_oe(fs_oe), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_oe(sdo_oe));
  codec_partner i_codec (.run(run), .word(16'h3c96), .sck(sck), .fs(fs), .sdi(sdi));
  always #4 mclk = ~mclk;
  // ****
  // access tasks
  // ****
  task automatic conclude;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    integer k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic wait_stat(input logic [31:0] m);
    integer k;
    k = 0;
    do begin
      apb(1'b0, `ADDR_STATUS, 32'h0);
      k++;
    end while ((rd & m) !== m && k < 1000);
    check("status wait", rd & m, m);
    if ((rd & m) !== m) conclude();
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    {mclk, rst_n, psel, penable, pwrite, cpu_idle, run, paddr, pwdata} = '0;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (n = 0; n < 5; n++) begin
      rdc("reset value", regs[n], 32'h0);
    end
    rdc("status reset", `ADDR_STATUS, 32'h1);
    rdc("unmapped read", 8'h20, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, `ADDR_CONTROL_2, 32'hffffffff);
    rdc("control_2 bits", `ADDR_CONTROL_2, {16'h0, `MASK_CONTROL_2});
    apb(1'b1, `ADDR_CONTROL_1, 32'h7fff);
    rdc("control_1 bits", `ADDR_CONTROL_1, 32'h2fe3);
    for (n = 0; n < 4; n++) begin
      apb(1'b1, `ADDR_CONTROL_1, n);
      rdc("framing code", `ADDR_CONTROL_1, n);
    end
    // loopback, one 16-bit word a frame, resend on underflow
    apb(1'b1, `ADDR_CONTROL_2, 32'h000f);
    apb(1'b1, `ADDR_RX_SLOT_MASK, 32'h1);
    apb(1'b1, `ADDR_TX_SLOT_MASK, 32'h1);
    apb(1'b1, `ADDR_TX_DATA, 32'ha5c3);
    apb(1'b1, `ADDR_CONTROL_1, 32'h88a0);
    for (n = 0; n < 2; n++) begin
      wait_stat(32'h4);
      rdc("loopback word", `ADDR_RX_DATA, 32'ha5c3);
    end
    check("clock drive on", {31'h0, sck_oe}, 32'h1);
    check("sync drive on", {31'h0, fs_oe}, 32'h1);
    // one 16-bit frame is 32 clocks; sync stays high for one bit of two clocks
    n = 0;
    repeat (64) begin
      @(posedge mclk);
      n = n + fs_out;
    end
    check("sync pulses", n, 32'h4);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check("underflow flags", rd & 32'h3, 32'h3);
    // idle stop freezes the generated clock
    apb(1'b1, `ADDR_CONTROL_1, 32'ha8a0);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge mclk);
    held = sck_out;
    repeat (21) @(posedge mclk);
    check("idle clock", {31'h0, sck_out}, {31'h0, held});
    cpu_idle <= 1'b0;
    // external clock and sync, four words a buffer
    apb(1'b1, `ADDR_CONTROL_1, 32'h0);
    for (n = 0; n < 4; n++) begin
      apb(1'b0, `ADDR_RX_DATA, 32'h0);
    end
    apb(1'b1, `ADDR_CONTROL_2, 32'h0c0f);
    apb(1'b1, `ADDR_CONTROL_1, 32'h8520);
    run <= 1'b1;
    wait_stat(32'h4);
    check("clock drive", {31'h0, sck_oe}, 32'h0);
    check("sync drive", {31'h0, fs_oe}, 32'h0);
    apb(1'b0, `ADDR_RX_DATA, 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check("full after pop", rd & 32'h4, 32'h0);
    for (n = 0; n < 3; n++) begin
      apb(1'b0, `ADDR_RX_DATA, 32'h0);
    end
    check("codec word", rd, 32'h3c96);
    run <= 1'b0;
    conclude();
  end
endmodule
